// File: verilog/hsmon_consts.svh
// Purpose: constants of the hot swap monitor readback block
// Assumes: included by bare name before the modules that use it
// Notes:   definitions only
`ifndef HSMON_CONSTS_SVH
`define HSMON_CONSTS_SVH

// ****************************************
// reset values
// ****************************************
`define HSMON_THR_RESET    8'hFF
`define HSMON_CTRL_RESET   8'h00
`define HSMON_AEN_RESET    8'h04
`define HSMON_SLAVE_ADDR   7'h10
`define HSMON_BYTE_IDLE    8'hFF

// ****************************************
// write targets, extended address low bits
// ****************************************
`define HSMON_SEL_CMD      2'h0
`define HSMON_SEL_AEN      2'h1
`define HSMON_SEL_THR      2'h2
`define HSMON_SEL_CTRL     2'h3
`define HSMON_EXT_FLAG     7

// ****************************************
// field positions
// ****************************************
`define HSMON_CMD_VCONT    0
`define HSMON_CMD_VONCE    1
`define HSMON_CMD_ICONT    2
`define HSMON_CMD_IONCE    3
`define HSMON_CMD_VRANGE   4
`define HSMON_CMD_STATRD   6
`define HSMON_AEN_OC1      0
`define HSMON_AEN_OC4      1
`define HSMON_AEN_FAIL     2
`define HSMON_AEN_OFF      3
`define HSMON_AEN_CLR      4
`define HSMON_CTRL_FORCED_SHUTDOWN_BIT   0

// ****************************************
// link counts
// ****************************************
`define HSMON_LAST_BIT     3'h7
`define HSMON_LAST_IDX     2'h3

`endif

// File: verilog/hsmon_pkg.sv
// Purpose: shared types of the hot swap monitor readback block
// Assumes: constants live in hsmon_consts.svh
// Notes:   types only
package hsmon_pkg;

  // link states, gray along address, ack, byte, ack
  typedef enum logic [2:0]
  {
    ST_IDLE = 3'h0,
    ST_ADDR = 3'h1,
    ST_AACK = 3'h3,
    ST_WRB  = 3'h2,
    ST_WACK = 3'h6,
    ST_RDB  = 3'h7,
    ST_RACK = 3'h5
  } hsmon_state_t;

  typedef struct packed {
    logic       volt_cont;
    logic       volt_once;
    logic       curr_cont;
    logic       curr_once;
    logic       volt_range;
  } hsmon_conv_ctrl_t;

  typedef struct packed {
    logic [1:0] zero;
    logic       off_alert;
    logic       off_status;
    logic       fail_flag;
    logic       analog_trip;
    logic       trip_alert;
    logic       trip_cmp;
  } hsmon_status_t;

  typedef struct packed {
    logic [1:0] sel;
    logic [7:0] data;
  } hsmon_wr_t;

endpackage

// File: verilog/hsmon_sync.sv
// Purpose: two flip-flop level synchroniser
// Assumes: bits are independent levels or slow toggles
// Notes:   first stage is read by the second stage only
`timescale 1ns/10ps
module hsmon_sync #(
  parameter int WIDTH = 1
) (
  input  wire logic             i_clk,
  input  wire logic             i_rst,
  input  wire logic [WIDTH-1:0] i_d,
  output logic      [WIDTH-1:0] o_q
);

  logic [WIDTH-1:0] meta_reg;
  logic [WIDTH-1:0] q_reg;

  always_ff @(posedge i_clk)
  begin
    if (i_rst)
    begin
      meta_reg <= '0;
      q_reg    <= '0;
    end
    else
    begin
      meta_reg <= i_d;
      q_reg    <= meta_reg;
    end
  end

  assign o_q = q_reg;

endmodule

// File: verilog/hsmon_readback.sv
// Purpose: two-wire slave readback, status and extended registers
// Assumes: conversions and analog protection sit outside this block
// Notes:   link logic runs on scl and sda edges, the rest on i_clk
`timescale 1ns/10ps
`include "hsmon_consts.svh"

// Operation
// - 8-bit threshold, resets full scale
// - control bit 0 forces hot swap off
// - command selects combined, voltage or current
// - combined read: three bytes, packed low nibbles
// - voltage read: two bytes, low nibble zero
// - current read: two bytes, low nibble zero
// - ack address; master nacks last, stops
// - status read returns one status byte
// - status bit0: last three conversions over
// - status bit1: sticky digital trip alert
// - status bit2: analog overcurrent off state
// - status bit3: sticky hot swap failure
// - status bit4: pin off or software off
// - status bit5: sticky off alert
// - clear bit resets status bits 1,3,5
// - results are unsigned 12-bit codes
// - status select bit returns status byte
// - extended write: msb set, two select bits
// - clear bit returns to zero itself
// - nack reads while single conversion pending
module hsmon_readback
  import hsmon_pkg::*;
#(
  parameter int         CODE_W            = 12,
  parameter logic [6:0] SLAVE_ADDR        = `HSMON_SLAVE_ADDR,
  parameter bit         ENABLE_ACTIVE_LOW = 1'b0
) (
  input  wire logic              i_clk,
  input  wire logic              i_rst,
  input  wire logic              i_scl,
  input  wire logic              i_sda,
  output logic                   o_sda_out,
  output logic                   o_sda_oe_n,
  input  wire logic [CODE_W-1:0] i_volt_code,
  input  wire logic              i_volt_valid,
  input  wire logic [CODE_W-1:0] i_curr_code,
  input  wire logic              i_curr_valid,
  input  wire logic              i_enable_input_pin,
  input  wire logic              i_analog_trip_state,
  output logic                   o_swap_off,
  output hsmon_conv_ctrl_t       o_conv_ctrl
);

  // ****************************************
  // declarations
  // ****************************************
  logic [3:0]        sync_q;
  logic              wr_tgl_d_reg;
  logic [7:0]        thr_reg;
  logic [7:0]        ctrl_reg;
  logic [7:0]        aen_reg;
  logic [CODE_W-1:0] volt_reg;
  logic [CODE_W-1:0] curr_reg;
  logic [3:0]        hist_reg;
  logic              vbusy_reg;
  logic              ibusy_reg;
  logic              ana_d_reg;
  logic              off_d_reg;
  logic              off_state_reg;
  logic              trip_alert_reg;
  logic              fail_reg;
  logic              off_alert_reg;
  logic [CODE_W-1:0] hold_v_reg;
  logic [CODE_W-1:0] hold_i_reg;
  hsmon_status_t     hold_st_reg;
  hsmon_conv_ctrl_t  conv_reg;
  logic              swap_off_reg;

  logic              st_tgl_reg;
  logic              st_seen_reg;
  hsmon_state_t      state_reg;
  hsmon_state_t      state_next;
  logic [2:0]        cnt_reg;
  logic [2:0]        cnt_next;
  logic [1:0]        idx_reg;
  logic [1:0]        idx_next;
  logic [7:0]        shift_reg;
  logic              rw_reg;
  logic [1:0]        ext_sel_reg;
  logic [6:0]        cmd_reg;
  hsmon_wr_t         wr_pl_reg;
  logic              wr_tgl_reg;
  logic              active_reg;
  logic              bsy1_reg;
  logic              bsy2_reg;
  logic              sda_out_reg;
  logic              sda_oe_n_reg;

  // ****************************************
  // register side, system clock
  // ****************************************
  // pins and link levels pass two flops before use
  hsmon_sync #(
    .WIDTH (4)
  ) u_sync (
    .i_clk (i_clk),
    .i_rst (i_rst),
    // pin taken as an off level, so the reset value of the chain is not a deassert
    .i_d   ({wr_tgl_reg, active_reg, ~(i_enable_input_pin ^ ENABLE_ACTIVE_LOW),
             i_analog_trip_state}),
    .o_q   (sync_q)
  );

  wire       wr_evt   = sync_q[3] ^ wr_tgl_d_reg;
  wire       link_act = sync_q[2];
  wire       pin_on   = ~sync_q[1];
  wire       ana_now  = sync_q[0];
  wire       wr_cmd   = wr_evt && (wr_pl_reg.sel == `HSMON_SEL_CMD);
  wire [7:0] wdat     = wr_pl_reg.data;

  wire [7:0] thr_next  = (wr_evt && wr_pl_reg.sel == `HSMON_SEL_THR) ? wdat : thr_reg;
  wire [7:0] ctrl_next = (wr_evt && wr_pl_reg.sel == `HSMON_SEL_CTRL) ? wdat : ctrl_reg;
  // clear bit lives one cycle, long enough to reset the flags
  wire [7:0] aen_next  = (wr_evt && wr_pl_reg.sel == `HSMON_SEL_AEN) ? wdat
                       : {aen_reg[7:5], 1'b0, aen_reg[3:0]};
  wire       clr       = aen_reg[`HSMON_AEN_CLR];

  wire       over      = i_curr_code[CODE_W-1:CODE_W-8] > thr_reg;
  wire       over3     = over & (&hist_reg[2:0]);
  wire       trip_set  = i_curr_valid & ((aen_reg[`HSMON_AEN_OC1] & over)
                       | (aen_reg[`HSMON_AEN_OC4] & over3));
  wire       fail_set  = aen_reg[`HSMON_AEN_FAIL] & ana_now & ~ana_d_reg;
  wire       off_now   = ~pin_on | ctrl_reg[`HSMON_CTRL_FORCED_SHUTDOWN_BIT];
  wire       off_set   = aen_reg[`HSMON_AEN_OFF] & off_now & ~off_d_reg;

  hsmon_status_t status_now;
  assign status_now = '{zero:        2'h0,
                        off_alert:   off_alert_reg,
                        off_status:  off_state_reg,
                        fail_flag:   fail_reg,
                        analog_trip: ana_now,
                        trip_alert:  trip_alert_reg,
                        trip_cmp:    &hist_reg[2:0]};

  always_ff @(posedge i_clk)
  begin
    if (i_rst)
    begin
      wr_tgl_d_reg <= 1'b0;
      thr_reg      <= `HSMON_THR_RESET;
      ctrl_reg     <= `HSMON_CTRL_RESET;
      aen_reg      <= `HSMON_AEN_RESET;
    end
    else
    begin
      wr_tgl_d_reg <= sync_q[3];
      thr_reg      <= thr_next;
      ctrl_reg     <= ctrl_next;
      aen_reg      <= aen_next;
    end
  end

  // set wins over clear on every sticky flag
  always_ff @(posedge i_clk)
  begin
    if (i_rst)
    begin
      trip_alert_reg <= 1'b0;
      fail_reg       <= 1'b0;
      off_alert_reg  <= 1'b0;
      ana_d_reg      <= 1'b0;
      off_d_reg      <= 1'b0;
      off_state_reg  <= 1'b0;
      swap_off_reg   <= 1'b0;
    end
    else
    begin
      trip_alert_reg <= trip_set | (trip_alert_reg & ~clr);
      fail_reg       <= fail_set | (fail_reg & ~clr);
      off_alert_reg  <= off_set | (off_alert_reg & ~clr);
      ana_d_reg      <= ana_now;
      off_d_reg      <= off_now;
      off_state_reg  <= off_now;
      swap_off_reg   <= off_now;
    end
  end

  always_ff @(posedge i_clk)
  begin
    if (i_rst)
    begin
      volt_reg  <= '0;
      curr_reg  <= '0;
      hist_reg  <= 4'h0;
      vbusy_reg <= 1'b0;
      ibusy_reg <= 1'b0;
      conv_reg  <= '0;
    end
    else
    begin
      if (i_volt_valid)
        volt_reg <= i_volt_code;
      if (i_curr_valid)
      begin
        curr_reg <= i_curr_code;
        hist_reg <= {hist_reg[2:0], over};
      end
      vbusy_reg <= (wr_cmd & wdat[`HSMON_CMD_VONCE]) | (vbusy_reg & ~i_volt_valid);
      ibusy_reg <= (wr_cmd & wdat[`HSMON_CMD_IONCE]) | (ibusy_reg & ~i_curr_valid);
      if (wr_cmd)
        conv_reg <= '{wdat[`HSMON_CMD_VCONT], wdat[`HSMON_CMD_VONCE],
                      wdat[`HSMON_CMD_ICONT], wdat[`HSMON_CMD_IONCE],
                      wdat[`HSMON_CMD_VRANGE]};
      else
      begin
        conv_reg.volt_once <= 1'b0;
        conv_reg.curr_once <= 1'b0;
      end
    end
  end

  // snapshot frozen during read frames and address phases, so the link reads stable words
  always_ff @(posedge i_clk)
  begin
    if (i_rst)
    begin
      hold_v_reg  <= '0;
      hold_i_reg  <= '0;
      hold_st_reg <= '0;
    end
    else if (!link_act)
    begin
      hold_v_reg  <= volt_reg;
      hold_i_reg  <= curr_reg;
      hold_st_reg <= status_now;
    end
  end

  // ****************************************
  // link side, scl and sda edges
  // ****************************************
  // sda falling while scl high marks a start
  always_ff @(negedge i_sda or posedge i_rst)
  begin
    if (i_rst)
      st_tgl_reg <= 1'b0;
    else if (i_scl)
      st_tgl_reg <= ~st_tgl_reg;
  end

  function automatic logic [7:0] pick_byte(input logic [6:0]        cmd,
                                            input logic [1:0]        idx,
                                            input logic [CODE_W-1:0] v,
                                            input logic [CODE_W-1:0] c,
                                            input logic [7:0]        st);
    logic vs;
    logic cs;
    vs = cmd[`HSMON_CMD_VCONT] | cmd[`HSMON_CMD_VONCE];
    cs = cmd[`HSMON_CMD_ICONT] | cmd[`HSMON_CMD_IONCE];
    pick_byte = `HSMON_BYTE_IDLE;
    if (cmd[`HSMON_CMD_STATRD])
    begin
      if (idx == 2'h0)
        pick_byte = st;
    end
    else if (vs && !cs)
    begin
      if (idx == 2'h0)
        pick_byte = v[11:4];
      else if (idx == 2'h1)
        pick_byte = {v[3:0], 4'h0};
    end
    else if (cs && !vs)
    begin
      if (idx == 2'h0)
        pick_byte = c[11:4];
      else if (idx == 2'h1)
        pick_byte = {c[3:0], 4'h0};
    end
    else
    begin
      if (idx == 2'h0)
        pick_byte = v[11:4];
      else if (idx == 2'h1)
        pick_byte = c[11:4];
      else if (idx == 2'h2)
        pick_byte = {v[3:0], c[3:0]};
    end
  endfunction

  wire       start_new = st_tgl_reg ^ st_seen_reg;
  wire [7:0] rx_byte   = {shift_reg[6:0], i_sda};
  wire       last_bit  = (cnt_reg == `HSMON_LAST_BIT);
  wire       addr_hit  = (rx_byte[7:1] == SLAVE_ADDR);
  wire       addr_ack  = addr_hit & ~(rx_byte[0] & bsy2_reg);
  wire       wr_done   = (state_reg == ST_WRB) && last_bit && !start_new;
  wire       is_ext    = rx_byte[`HSMON_EXT_FLAG];
  wire       wr_issue  = wr_done && ((idx_reg == 2'h0 && !is_ext)
                       || (idx_reg == 2'h1 && ext_sel_reg != `HSMON_SEL_CMD));
  wire [1:0] wr_sel    = (idx_reg == 2'h0) ? `HSMON_SEL_CMD : ext_sel_reg;
  wire [1:0] idx_inc   = (idx_reg == `HSMON_LAST_IDX) ? idx_reg : idx_reg + 2'h1;
  wire [7:0] tx_byte   = pick_byte(cmd_reg, idx_reg, hold_v_reg, hold_i_reg,
                                   hold_st_reg);
  wire       drive_low = (state_reg == ST_AACK) || (state_reg == ST_WACK)
                       || ((state_reg == ST_RDB) && !tx_byte[~cnt_reg]);
  // stop is not decoded, so a write frame never goes idle; past the address ack only reads freeze the snapshot
  wire       rd_frame  = (state_next != ST_IDLE) && (state_next != ST_WRB)
                       && (state_next != ST_WACK);

  always_comb
  begin
    state_next = state_reg;
    cnt_next   = cnt_reg + 3'h1;
    idx_next   = idx_reg;
    if (start_new)
    begin
      // stray stop or nack edges leave the count dirty; a start restarts it
      state_next = ST_ADDR;
      idx_next   = 2'h0;
      cnt_next   = 3'h1;
    end
    else
    begin
      case (state_reg)
        ST_ADDR: if (last_bit) state_next = addr_ack ? ST_AACK : ST_IDLE;
        ST_AACK: state_next = rw_reg ? ST_RDB : ST_WRB;
        ST_WRB:  if (last_bit) state_next = ST_WACK;
        ST_RDB:  if (last_bit) state_next = ST_RACK;
        ST_WACK:
        begin
          state_next = ST_WRB;
          idx_next   = idx_inc;
        end
        // a nack ends the read; two-byte modes rely on it after byte two
        ST_RACK:
        begin
          state_next = i_sda ? ST_IDLE : ST_RDB;
          idx_next   = idx_inc;
        end
        default: state_next = ST_IDLE;
      endcase
    end
  end

  always_ff @(posedge i_scl or posedge i_rst)
  begin
    if (i_rst)
    begin
      st_seen_reg <= 1'b0;
      state_reg   <= ST_IDLE;
      cnt_reg     <= 3'h0;
      idx_reg     <= 2'h0;
      shift_reg   <= 8'h00;
      rw_reg      <= 1'b0;
      active_reg  <= 1'b0;
      bsy1_reg    <= 1'b0;
      bsy2_reg    <= 1'b0;
    end
    else
    begin
      st_seen_reg <= st_tgl_reg;
      state_reg   <= state_next;
      cnt_reg     <= (state_next == ST_ADDR || state_next == state_reg) ? cnt_next : 3'h0;
      idx_reg     <= idx_next;
      shift_reg   <= start_new ? {7'h00, i_sda} : rx_byte;
      if (state_reg == ST_ADDR && last_bit)
        rw_reg <= rx_byte[0];
      active_reg  <= rd_frame;
      bsy1_reg    <= vbusy_reg | ibusy_reg;
      bsy2_reg    <= bsy1_reg;
    end
  end

  // command kept here for byte selection, also sent across for conversions
  always_ff @(posedge i_scl or posedge i_rst)
  begin
    if (i_rst)
    begin
      ext_sel_reg <= `HSMON_SEL_CMD;
      cmd_reg     <= 7'h00;
      wr_pl_reg   <= '0;
      wr_tgl_reg  <= 1'b0;
    end
    else
    begin
      if (wr_done && idx_reg == 2'h0)
        ext_sel_reg <= is_ext ? rx_byte[1:0] : `HSMON_SEL_CMD;
      if (wr_done && idx_reg == 2'h0 && !is_ext)
        cmd_reg <= rx_byte[6:0];
      if (wr_issue)
      begin
        wr_pl_reg  <= '{sel: wr_sel, data: rx_byte};
        wr_tgl_reg <= ~wr_tgl_reg;
      end
    end
  end

  // open drain: only ever pulls low, changes on the falling scl edge
  always_ff @(negedge i_scl or posedge i_rst)
  begin
    if (i_rst)
    begin
      sda_out_reg  <= 1'b0;
      sda_oe_n_reg <= 1'b1;
    end
    else
    begin
      sda_out_reg  <= 1'b0;
      sda_oe_n_reg <= ~drive_low;
    end
  end

  assign o_sda_out   = sda_out_reg;
  assign o_sda_oe_n  = sda_oe_n_reg;
  assign o_swap_off  = swap_off_reg;
  assign o_conv_ctrl = conv_reg;

  // ****************************************
  // checks
  // ****************************************
  wire vs_w = cmd_reg[`HSMON_CMD_VCONT] | cmd_reg[`HSMON_CMD_VONCE];
  wire cs_w = cmd_reg[`HSMON_CMD_ICONT] | cmd_reg[`HSMON_CMD_IONCE];

  sequence s_clear_write;
    wr_evt && wr_pl_reg.sel == `HSMON_SEL_AEN && wdat[`HSMON_AEN_CLR];
  endsequence
  sequence s_no_new_set;
    !trip_set && !fail_set && !off_set && !wr_evt;
  endsequence

  thr_reset_a: assert property (@(posedge i_clk) $fell(i_rst) |-> thr_reg == 8'hFF)
    else $error("threshold not full scale after reset");
  forced_shutdown_bit_force_a: assert property (@(posedge i_clk) disable iff (i_rst)
    ctrl_reg[0] |=> o_swap_off) else $error("software off did not force off");
  off_status_a: assert property (@(posedge i_clk) disable iff (i_rst)
    off_now |=> status_now.off_status) else $error("off status not set");
  over_cmp_a: assert property (@(posedge i_clk) disable iff (i_rst)
    (i_curr_valid && i_curr_code[11:4] > thr_reg) |=> hist_reg[0])
    else $error("over threshold not recorded");
  trip_three_a: assert property (@(posedge i_clk) disable iff (i_rst)
    (i_curr_valid && i_curr_code[11:4] > thr_reg && hist_reg[1:0] == 2'h3)
    |=> status_now.trip_cmp) else $error("trip compare missed three overs");
  trip_sticky_a: assert property (@(posedge i_clk) disable iff (i_rst)
    (trip_alert_reg && !clr) |=> trip_alert_reg) else $error("trip alert lost");
  clear_cycle_a: assert property (@(posedge i_clk) disable iff (i_rst)
    s_clear_write ##1 s_no_new_set |=> !trip_alert_reg && !fail_reg && !off_alert_reg
    && !aen_reg[4] && status_now.off_status == off_state_reg)
    else $error("clear did not reset sticky flags");
  top_zero_a: assert property (@(posedge i_clk) disable iff (i_rst)
    hold_st_reg[7:6] == 2'h0) else $error("unused status bits set");
  nack_busy_a: assert property (@(posedge i_scl) disable iff (i_rst)
    (state_reg == ST_ADDR && last_bit && !start_new && rx_byte[0] && bsy2_reg)
    |=> state_reg == ST_IDLE) else $error("read acked while converting");
  byte_three_a: assert property (@(posedge i_scl) disable iff (i_rst)
    (!cmd_reg[6] && vs_w == cs_w && idx_reg == 2'h2)
    |-> tx_byte == {hold_v_reg[3:0], hold_i_reg[3:0]}) else $error("bad third byte");
  volt_only_a: assert property (@(posedge i_scl) disable iff (i_rst)
    (!cmd_reg[6] && vs_w && !cs_w && idx_reg == 2'h1)
    |-> tx_byte == {hold_v_reg[3:0], 4'h0}) else $error("bad voltage low byte");
  curr_only_a: assert property (@(posedge i_scl) disable iff (i_rst)
    (!cmd_reg[6] && cs_w && !vs_w && idx_reg == 2'h0)
    |-> tx_byte == hold_i_reg[11:4]) else $error("bad current high byte");
  status_sel_a: assert property (@(posedge i_scl) disable iff (i_rst)
    (cmd_reg[6] && idx_reg == 2'h0) |-> tx_byte == hold_st_reg)
    else $error("status byte not selected");

endmodule

// File: tb/hsmon_i2c_master.sv
// Purpose: behavioural two-wire master for the readback block
// Assumes: sda is resolved with a pull-up in the bench
// Notes:   scl stands still between frames
`timescale 1ns/10ps
module hsmon_i2c_master (
  output logic      o_scl,
  output logic      o_sda,
  input  wire logic i_sda
);
  // quarter of the 125 ns link period
  localparam realtime Q = 31.25;

  initial
  begin
    o_scl = 1'b1;
    o_sda = 1'b1;
  end

  task automatic start();
    o_sda = 1'b1;
    o_scl = 1'b1;
    #(2*Q) o_sda = 1'b0;
    #(2*Q) o_scl = 1'b0;
  endtask

  task automatic stop();
    #Q o_sda = 1'b0;
    #Q o_scl = 1'b1;
    #(2*Q) o_sda = 1'b1;
    #(2*Q);
  endtask

  // data moves mid low phase, so it never races the slave's falling edge
  task automatic xfer(input logic [7:0] tx, input logic mack,
                      output logic [7:0] rx, output logic ack);
    for (int i = 7; i >= 0; i--)
    begin
      #Q o_sda = tx[i];
      #Q o_scl = 1'b1;
      rx[i] = i_sda;
      #(2*Q) o_scl = 1'b0;
    end
    #Q o_sda = mack;
    #Q o_scl = 1'b1;
    ack = i_sda;
    #(2*Q) o_scl = 1'b0;
  endtask
endmodule

// File: tb/hsmon_readback_bench.sv
// Purpose: self-checking bench of the readback block
// Assumes: slave address 7'h10, enable pin active high
// Notes:   status is read by command 8'h40 then a one-byte read
`timescale 1ns/10ps
module hsmon_readback_bench
  import hsmon_pkg::*;
;
  logic             clk;
  logic             rst;
  logic             m_scl;
  logic             m_sda;
  logic             vvalid;
  logic             cvalid;
  logic             pin;
  logic             trip;
  logic [11:0]      vcode;
  logic [11:0]      ccode;
  wire logic        sda_line;
  logic             sda_out;
  logic             sda_oe_n;
  logic             swap_off;
  hsmon_conv_ctrl_t conv_ctrl;
  logic [7:0]       rx;
  logic             ack;
  int               err_count = 0;
  int               comparisons = 0;
  int               cycles = 0;

  // pull-up: released unless the master or the slave pulls low
  assign sda_line = m_sda & (sda_oe_n | sda_out);

  hsmon_readback u_hsmon_readback (
    .i_clk(clk), .i_rst(rst), .i_scl(m_scl), .i_sda(sda_line),
    .o_sda_out(sda_out), .o_sda_oe_n(sda_oe_n),
    .i_volt_code(vcode), .i_volt_valid(vvalid),
    .i_curr_code(ccode), .i_curr_valid(cvalid),
    .i_enable_input_pin(pin), .i_analog_trip_state(trip),
    .o_swap_off(swap_off), .o_conv_ctrl(conv_ctrl)
  );

  hsmon_i2c_master u_hsmon_i2c_master (
    .o_scl(m_scl), .o_sda(m_sda), .i_sda(sda_line)
  );

  initial
  begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  // ****
  // helpers
  // ****
  task automatic final_report();
    $display("errors=%0d comparisons=%0d", err_count, comparisons);
    if (err_count == 0 && comparisons > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 30000)
    begin
      err_count++;
      final_report();
    end
  end

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      err_count++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic wait_clk(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  task automatic wr(input logic [7:0] b0, input logic [7:0] b1, input bit two);
    u_hsmon_i2c_master.start();
    u_hsmon_i2c_master.xfer(8'h20, 1'b1, rx, ack);
    chk({7'h0, ack}, 8'h00);
    u_hsmon_i2c_master.xfer(b0, 1'b1, rx, ack);
    if (two)
      u_hsmon_i2c_master.xfer(b1, 1'b1, rx, ack);
    chk({7'h0, ack}, 8'h00);
    u_hsmon_i2c_master.stop();
    wait_clk(10);
  endtask

  // master nacks only the last byte
  task automatic rd(input int n, input logic [23:0] exp);
    u_hsmon_i2c_master.start();
    u_hsmon_i2c_master.xfer(8'h21, 1'b1, rx, ack);
    chk({7'h0, ack}, 8'h00);
    for (int i = 0; i < n; i++)
    begin
      u_hsmon_i2c_master.xfer(8'hFF, i == n - 1, rx, ack);
      chk(rx, exp[23 - 8 * i -: 8]);
    end
    u_hsmon_i2c_master.stop();
    wait_clk(10);
  endtask

  task automatic probe(input logic [7:0] addr);
    u_hsmon_i2c_master.start();
    u_hsmon_i2c_master.xfer(addr, 1'b1, rx, ack);
    chk({7'h0, ack}, 8'h01);
    u_hsmon_i2c_master.stop();
    wait_clk(10);
  endtask

  task automatic st(input logic [7:0] exp);
    wr(8'h40, 8'h00, 1'b0);
    rd(1, {exp, 16'h0000});
  endtask

  task automatic conv(input logic [11:0] v, input logic [11:0] c);
    vcode = v;
    ccode = c;
    vvalid = 1'b1;
    cvalid = 1'b1;
    wait_clk(1);
    vvalid = 1'b0;
    cvalid = 1'b0;
    wait_clk(4);
  endtask

  // ****
  // scenarios
  // ****
  task automatic t_analog();
    trip = 1'b1;
    wait_clk(10);
    st(8'h0C);
    trip = 1'b0;
    wait_clk(10);
    st(8'h08);
    wr(8'h81, 8'h14, 1'b1);
    st(8'h00);
    // a stuck clear bit would wipe this second set a cycle after it lands
    trip = 1'b1;
    wait_clk(10);
    st(8'h0C);
    trip = 1'b0;
    wr(8'h81, 8'h14, 1'b1);
    st(8'h00);
  endtask

  task automatic t_formats();
    logic [7:0]  cmds [4];
    logic [7:0]  ctls [4];
    logic [23:0] exps [4];
    int          lens [4];
    cmds = '{8'h15, 8'h01, 8'h04, 8'h00};
    ctls = '{8'h15, 8'h10, 8'h04, 8'h00};
    exps = '{24'hAB_5DC7, 24'hAB_C000, 24'h5D_7000, 24'hAB_5DC7};
    lens = '{3, 2, 2, 3};
    conv(12'hABC, 12'h5D7);
    for (int i = 0; i < 4; i++)
    begin
      wr(cmds[i], 8'h00, 1'b0);
      chk({3'h0, conv_ctrl}, ctls[i]);
      rd(lens[i], exps[i]);
    end
  endtask

  task automatic t_trip();
    repeat (3) conv(12'h000, 12'hFFF);
    st(8'h00);
    wr(8'h82, 8'h5D, 1'b1);
    wr(8'h81, 8'h05, 1'b1);
    repeat (3) conv(12'h000, 12'h5E0);
    st(8'h03);
    conv(12'h000, 12'h5D0);
    st(8'h02);
    wr(8'h81, 8'h15, 1'b1);
    st(8'h00);
    // single trip disabled: only the fourth over in a row may alert
    wr(8'h81, 8'h12, 1'b1);
    repeat (3) conv(12'h000, 12'h5E0);
    st(8'h01);
    conv(12'h000, 12'h5E0);
    st(8'h03);
    wr(8'h81, 8'h14, 1'b1);
    st(8'h01);
    conv(12'h000, 12'h000);
  endtask

  task automatic t_off();
    wr(8'h81, 8'h0C, 1'b1);
    pin = 1'b0;
    wait_clk(10);
    chk({7'h0, swap_off}, 8'h01);
    st(8'h30);
    pin = 1'b1;
    wait_clk(10);
    st(8'h20);
    wr(8'h81, 8'h1C, 1'b1);
    st(8'h00);
    wr(8'h83, 8'h01, 1'b1);
    chk({7'h0, swap_off}, 8'h01);
    st(8'h30);
    wr(8'h83, 8'h00, 1'b1);
    chk({7'h0, swap_off}, 8'h00);
    wr(8'h81, 8'h14, 1'b1);
    st(8'h00);
  endtask

  task automatic t_once();
    probe(8'h22);
    wr(8'h02, 8'h00, 1'b0);
    chk({3'h0, conv_ctrl}, 8'h00);
    probe(8'h21);
    conv(12'h123, 12'h000);
    rd(2, 24'h12_3000);
  endtask

  initial
  begin
    rst = 1'b1;
    pin = 1'b1;
    trip = 1'b0;
    vvalid = 1'b0;
    cvalid = 1'b0;
    vcode = 12'h000;
    ccode = 12'h000;
    repeat (20) @(posedge clk);
    #1 rst = 1'b0;
    wait_clk(5);
    st(8'h00);
    t_analog();
    t_formats();
    t_trip();
    t_off();
    t_once();
    final_report();
  end
endmodule
